// ### pkg/eprc_consts.vh
`ifndef EPRC_CONSTS_VH
`define EPRC_CONSTS_VH
// Register indexes within one link; byte address is four times the index
`define EPRC_IDX_TX_STATUS  8'hc8
`define EPRC_IDX_TX_CTRL    8'hc9
`define EPRC_IDX_TX_DATA    8'hca
`define EPRC_IDX_TX_CFG     8'hcb
`define EPRC_IDX_TX_EN      8'hcc
`define EPRC_IDX_RX_STATUS  8'hcd
`define EPRC_IDX_RX_CTRL    8'hce
`define EPRC_IDX_RX_DATA    8'hcf
`define EPRC_IDX_RX_CFG     8'hd0
`define EPRC_IDX_RX_EN      8'hd1
// Link select sits above the register index (stride 400H)
`define EPRC_LINK_HI        11
`define EPRC_LINK_LO        10
`define EPRC_IDX_HI         9
`define EPRC_IDX_LO         2
// Field positions
`define EPRC_CFG_SNAP       7
`define EPRC_CFG_GSTRK      6
`define EPRC_CFG_GSEL_HI    2
`define EPRC_CFG_GSEL_LO    0
`define EPRC_EN_BIT         0
`define EPRC_CTRL_RNW       7
`define EPRC_CTRL_ADDR_HI   6
`define EPRC_STAT_BUSY      0
`define EPRC_SEL_HI         7
`define EPRC_SEL_LO         5
`define EPRC_STRK_BIT       4
// Reset values
`define EPRC_TX_CFG_RST     8'h80
`define EPRC_RX_CFG_RST     8'h00
`define EPRC_EN_RST         8'h00
`define EPRC_CTRL_RST       8'h00
`define EPRC_DATA_RST       8'h00
// Replacement codes
`define EPRC_SEL_SLOT       3'h0
`define EPRC_SEL_TRUNK      3'h1
`define EPRC_SEL_ALAW       3'h2
`define EPRC_SEL_ULAW       3'h3
`define EPRC_SEL_LOOP       3'h4
// Indirect map
`define EPRC_TRUNK_BASE     7'h20
`define EPRC_SIG_BASE       7'h40
`define EPRC_SIG_GAP        7'h50
`define EPRC_IND_LAST       7'h5f
`define EPRC_MEM_DEPTH      96
// Indirect access time in pclk cycles
`define EPRC_IND_CYCLES     2'h2
`endif

// ### rtl/eprc_indirect.v
`timescale 1ns/1ps
`default_nettype none
`include "eprc_consts.vh"
module eprc_indirect (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       ctrl_wr,
   input  wire       data_wr,
   input  wire [7:0] wdata,
   output reg  [7:0] ctrl_q,
   output reg  [7:0] data_q,
   output reg        busy_q,
   input  wire [4:0] slot,
   output wire [2:0] slot_replace_sel,
   output wire [7:0] data_trunk_code,
   output wire       slot_sig_conditioning_en,
   output wire [3:0] slot_abcd
);
   reg  [7:0] mem_q [0:`EPRC_MEM_DEPTH-1];
   reg  [1:0] cnt_q;
   wire [6:0] addr   = ctrl_q[`EPRC_CTRL_ADDR_HI:0];
   wire       mapped = (addr < `EPRC_SIG_BASE) ||
                       ((addr > `EPRC_SIG_BASE) && (addr <= `EPRC_IND_LAST) &&
                        (addr != `EPRC_SIG_GAP));
   wire [6:0] a_trk  = `EPRC_TRUNK_BASE + {2'b00, slot};
   wire [6:0] a_sig  = `EPRC_SIG_BASE + {2'b00, slot};
   integer i;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `EPRC_CTRL_RST;
         data_q <= `EPRC_DATA_RST;
         busy_q <= 1'b0;
         cnt_q  <= 2'h0;
         for (i = 0; i < `EPRC_MEM_DEPTH; i = i + 1) begin
            mem_q[i] <= 8'h00;
         end
      end else if (busy_q) begin
         // New commands while busy are dropped, not queued
         if (cnt_q == 2'h1) begin
            busy_q <= 1'b0;
            if (ctrl_q[`EPRC_CTRL_RNW]) begin
               data_q <= mapped ? mem_q[addr] : 8'h00;
            end else if (mapped) begin
               mem_q[addr] <= data_q;
            end
         end
         cnt_q <= cnt_q - 2'h1;
      end else if (ctrl_wr) begin
         ctrl_q <= wdata;
         busy_q <= 1'b1;
         cnt_q  <= `EPRC_IND_CYCLES;
      end else if (data_wr) begin
         data_q <= wdata;
      end
   end

   assign slot_replace_sel         = mem_q[slot][`EPRC_SEL_HI:`EPRC_SEL_LO];
   assign data_trunk_code          = mem_q[a_trk];
   assign slot_sig_conditioning_en = mem_q[a_sig][`EPRC_STRK_BIT];
   assign slot_abcd                = mem_q[a_sig][3:0];
endmodule
`default_nettype wire

// ### rtl/eprc_top.v
// Contract
// - Indirect per-slot registers at 00-3F, 41-4F, 51-5F via 7-bit address.
// - Read: host writes address with direction 1, device fills data register.
// - Direction bit 0 selects indirect write, 1 selects indirect read.
// - Busy reads 1 while an indirect access runs, else 0.
// - Tx snapshot latches first-frame signaling, used for whole multiframe.
// - Rx snapshot latches first-frame signaling, output for whole multiframe.
// - Global conditioning replaces the ABCD of every slot except 0 and 16 with its own code.
// - Without global conditioning, only slots with their enable get replaced.
// - Global select 000 follows each slot's own replacement field.
// - Global select 001 replaces all data with per-slot trunk code.
// - Select 010 gives A-law milliwatt, 011 gives mu-law milliwatt.
// - Transmit select 100 replaces data with receive loopback data.
// - Transmit enable 0 disables all transmit functions, 1 enables.
// - Receive enable 0 disables all receive functions, 1 enables.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "eprc_consts.vh"
module eprc_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   input  wire [3:0]  tx_valid,
   input  wire [19:0] tx_slot,
   input  wire [31:0] tx_data_in,
   input  wire [15:0] tx_signaling_in,
   input  wire [3:0]  tx_frame_start,
   input  wire [3:0]  tx_mf_first,
   input  wire [3:0]  tx_mf_active,
   input  wire [31:0] tx_loop_data,
   output reg  [3:0]  tx_out_valid,
   output reg  [31:0] tx_data_out,
   output reg  [15:0] tx_sig_out,
   input  wire [3:0]  rx_valid,
   input  wire [19:0] rx_slot,
   input  wire [31:0] rx_data_in,
   input  wire [15:0] rx_sig_in,
   input  wire [3:0]  rx_frame_start,
   input  wire [3:0]  rx_mf_first,
   input  wire [3:0]  rx_mf_active,
   output reg  [3:0]  rx_out_valid,
   output reg  [31:0] rx_data_out,
   output reg  [15:0] rx_signaling_out
);
   // Zero wait states; read data is caught in the setup phase
   assign pready = 1'b1;

   wire       setup  = psel & ~penable;
   wire       wr_acc = psel & penable & pwrite;
   wire [1:0] link   = paddr[`EPRC_LINK_HI:`EPRC_LINK_LO];
   wire [7:0] ridx   = paddr[`EPRC_IDX_HI:`EPRC_IDX_LO];

   reg        hit;
   always @* begin
      case (ridx)
         `EPRC_IDX_TX_STATUS, `EPRC_IDX_TX_CTRL, `EPRC_IDX_TX_DATA,
         `EPRC_IDX_TX_CFG, `EPRC_IDX_TX_EN, `EPRC_IDX_RX_STATUS,
         `EPRC_IDX_RX_CTRL, `EPRC_IDX_RX_DATA, `EPRC_IDX_RX_CFG,
         `EPRC_IDX_RX_EN: hit = (paddr[1:0] == 2'b00);
         default: hit = 1'b0;
      endcase
   end

   function [7:0] mw_byte;
      input       ulaw;
      input [2:0] ph;
      reg   [7:0] b;
      begin
         case (ph[1:0])
            2'd0, 2'd3: b = ulaw ? 8'h1e : 8'h34;
            default:    b = ulaw ? 8'h0b : 8'h21;
         endcase
         // Second half of the cycle is the negative half-wave
         mw_byte = ph[2] ? (b | 8'h80) : b;
      end
   endfunction

   function [7:0] pick_data;
      input [2:0] gsel;
      input [2:0] ssel;
      input       is_tx;
      input [7:0] din;
      input [7:0] trunk;
      input [7:0] loopd;
      input [2:0] ph;
      reg   [2:0] sel;
      begin
         sel = (gsel == `EPRC_SEL_SLOT) ? ssel : gsel;
         case (sel)
            `EPRC_SEL_TRUNK: pick_data = trunk;
            `EPRC_SEL_ALAW:  pick_data = mw_byte(1'b0, ph);
            `EPRC_SEL_ULAW:  pick_data = mw_byte(1'b1, ph);
            `EPRC_SEL_LOOP:  pick_data = is_tx ? loopd : din;
            // Reserved codes pass data untouched
            default:         pick_data = din;
         endcase
      end
   endfunction

   wire [7:0] rd_w [0:3];

   genvar l;
   generate
      for (l = 0; l < 4; l = l + 1) begin : g_link
         reg  [7:0] tx_cfg_q;
         reg  [7:0] tx_en_q;
         reg  [7:0] rx_cfg_q;
         reg  [7:0] rx_en_q;
         wire [7:0] tx_ctrl;
         wire [7:0] tx_dat;
         wire       tx_busy;
         wire [7:0] rx_ctrl;
         wire [7:0] rx_dat;
         wire       rx_busy;
         wire [2:0] tx_ssel;
         wire [7:0] tx_trk;
         wire       tx_strk;
         wire [3:0] tx_abcd;
         wire [2:0] rx_ssel;
         wire [7:0] rx_trk;
         wire       rx_strk;
         wire [3:0] rx_abcd;
         reg  [2:0] tx_ph_q;
         reg  [2:0] rx_ph_q;
         reg  [3:0] tx_snap_q [0:31];
         reg  [3:0] rx_snap_q [0:31];
         reg  [7:0] rd_b;
         // Refused (misaligned or unmapped) writes must not land
         wire       sel_l = (link == l) & wr_acc & hit;
         wire [4:0] tslot = tx_slot[l*5 +: 5];
         wire [4:0] rslot = rx_slot[l*5 +: 5];
         wire [3:0] tsig  = tx_signaling_in[l*4 +: 4];
         wire [3:0] rsig  = rx_sig_in[l*4 +: 4];
         wire       t_has = (tslot != 5'd0) && (tslot != 5'd16);
         wire       r_has = (rslot != 5'd0) && (rslot != 5'd16);
         wire       t_snp = tx_cfg_q[`EPRC_CFG_SNAP] & tx_mf_active[l];
         wire       r_snp = rx_cfg_q[`EPRC_CFG_SNAP] & rx_mf_active[l];
         wire [3:0] t_src = (t_snp & ~tx_mf_first[l]) ? tx_snap_q[tslot] : tsig;
         wire [3:0] r_src = (r_snp & ~rx_mf_first[l]) ? rx_snap_q[rslot] : rsig;
         wire       t_rep = t_has & (tx_cfg_q[`EPRC_CFG_GSTRK] | tx_strk);
         wire       r_rep = r_has & (rx_cfg_q[`EPRC_CFG_GSTRK] | rx_strk);
         wire       t_on  = tx_en_q[`EPRC_EN_BIT];
         wire       r_on  = rx_en_q[`EPRC_EN_BIT];

         eprc_indirect u_tx_ind (
            .pclk                     (pclk),
            .presetn                  (presetn),
            .ctrl_wr                  (sel_l && ridx == `EPRC_IDX_TX_CTRL),
            .data_wr                  (sel_l && ridx == `EPRC_IDX_TX_DATA),
            .wdata                    (pwdata[7:0]),
            .ctrl_q                   (tx_ctrl),
            .data_q                   (tx_dat),
            .busy_q                   (tx_busy),
            .slot                     (tslot),
            .slot_replace_sel         (tx_ssel),
            .data_trunk_code          (tx_trk),
            .slot_sig_conditioning_en (tx_strk),
            .slot_abcd                (tx_abcd)
         );

         eprc_indirect u_rx_ind (
            .pclk                     (pclk),
            .presetn                  (presetn),
            .ctrl_wr                  (sel_l && ridx == `EPRC_IDX_RX_CTRL),
            .data_wr                  (sel_l && ridx == `EPRC_IDX_RX_DATA),
            .wdata                    (pwdata[7:0]),
            .ctrl_q                   (rx_ctrl),
            .data_q                   (rx_dat),
            .busy_q                   (rx_busy),
            .slot                     (rslot),
            .slot_replace_sel         (rx_ssel),
            .data_trunk_code          (rx_trk),
            .slot_sig_conditioning_en (rx_strk),
            .slot_abcd                (rx_abcd)
         );

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tx_cfg_q <= `EPRC_TX_CFG_RST;
               tx_en_q  <= `EPRC_EN_RST;
               rx_cfg_q <= `EPRC_RX_CFG_RST;
               rx_en_q  <= `EPRC_EN_RST;
            end else if (sel_l) begin
               // Reserved bits are not stored and read as zero
               case (ridx)
                  `EPRC_IDX_TX_CFG: tx_cfg_q <= pwdata[7:0] & 8'hc7;
                  `EPRC_IDX_TX_EN:  tx_en_q  <= pwdata[7:0] & 8'h01;
                  `EPRC_IDX_RX_CFG: rx_cfg_q <= pwdata[7:0] & 8'hc7;
                  `EPRC_IDX_RX_EN:  rx_en_q  <= pwdata[7:0] & 8'h01;
                  default: ;
               endcase
            end
         end

         always @* begin
            case (ridx)
               `EPRC_IDX_TX_STATUS: rd_b = {7'h00, tx_busy};
               `EPRC_IDX_TX_CTRL:   rd_b = tx_ctrl;
               `EPRC_IDX_TX_DATA:   rd_b = tx_dat;
               `EPRC_IDX_TX_CFG:    rd_b = tx_cfg_q;
               `EPRC_IDX_TX_EN:     rd_b = tx_en_q;
               `EPRC_IDX_RX_STATUS: rd_b = {7'h00, rx_busy};
               `EPRC_IDX_RX_CTRL:   rd_b = rx_ctrl;
               `EPRC_IDX_RX_DATA:   rd_b = rx_dat;
               `EPRC_IDX_RX_CFG:    rd_b = rx_cfg_q;
               `EPRC_IDX_RX_EN:     rd_b = rx_en_q;
               default:             rd_b = 8'h00;
            endcase
         end
         assign rd_w[l] = rd_b;

         // Milliwatt phase steps once per frame; the frame-start slot still gets the previous frame's byte
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tx_ph_q <= 3'h0;
               rx_ph_q <= 3'h0;
            end else begin
               if (tx_frame_start[l]) begin
                  tx_ph_q <= tx_ph_q + 3'h1;
               end
               if (rx_frame_start[l]) begin
                  rx_ph_q <= rx_ph_q + 3'h1;
               end
            end
         end

         // Snapshot store needs no reset; it is only read after a fill
         always @(posedge pclk) begin
            if (tx_valid[l] && t_snp && tx_mf_first[l]) begin
               tx_snap_q[tslot] <= tsig;
            end
            if (rx_valid[l] && r_snp && rx_mf_first[l]) begin
               rx_snap_q[rslot] <= rsig;
            end
         end

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tx_out_valid[l]          <= 1'b0;
               tx_data_out[l*8 +: 8]    <= 8'h00;
               tx_sig_out[l*4 +: 4]     <= 4'h0;
               rx_out_valid[l]          <= 1'b0;
               rx_data_out[l*8 +: 8]    <= 8'h00;
               rx_signaling_out[l*4 +: 4] <= 4'h0;
            end else begin
               tx_out_valid[l] <= tx_valid[l];
               rx_out_valid[l] <= rx_valid[l];
               if (tx_valid[l]) begin
                  if (t_on) begin
                     tx_data_out[l*8 +: 8] <= pick_data(
                        tx_cfg_q[`EPRC_CFG_GSEL_HI:`EPRC_CFG_GSEL_LO], tx_ssel, 1'b1,
                        tx_data_in[l*8 +: 8], tx_trk, tx_loop_data[l*8 +: 8], tx_ph_q);
                     tx_sig_out[l*4 +: 4] <= t_rep ? tx_abcd : t_src;
                  end else begin
                     tx_data_out[l*8 +: 8] <= tx_data_in[l*8 +: 8];
                     tx_sig_out[l*4 +: 4]  <= tsig;
                  end
               end
               if (rx_valid[l]) begin
                  if (r_on) begin
                     rx_data_out[l*8 +: 8] <= pick_data(
                        rx_cfg_q[`EPRC_CFG_GSEL_HI:`EPRC_CFG_GSEL_LO], rx_ssel, 1'b0,
                        rx_data_in[l*8 +: 8], rx_trk, 8'h00, rx_ph_q);
                     rx_signaling_out[l*4 +: 4] <= r_rep ? rx_abcd : r_src;
                  end else begin
                     rx_data_out[l*8 +: 8]      <= rx_data_in[l*8 +: 8];
                     rx_signaling_out[l*4 +: 4] <= rsig;
                  end
               end
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= (hit && !pwrite) ? {24'h000000, rd_w[link]} : 32'h0000_0000;
         pslverr <= ~hit;
      end
   end
endmodule
`default_nettype wire

// ### sim/eprc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module eprc_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  tx_valid,
   input wire logic [3:0]  tx_out_valid,
   input wire logic [31:0] tx_data_out,
   input wire logic [3:0]  rx_valid,
   input wire logic [3:0]  rx_out_valid,
   input wire logic [31:0] rx_data_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence cfg_s;
      setup_s ##0 (paddr[1:0] == 2'h0 && paddr[9:2] == 8'hcb);
   endsequence
   misalign_err_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access not refused");
   mapped_ok_a: assert property (cfg_s |=> !pslverr)
      else $error("mapped access refused");
   read_upper_a: assert property (psel && penable |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access phase not ready");
   tx_latency_a: assert property (tx_valid[0] |=> tx_out_valid[0])
      else $error("tx output valid missing");
   tx_hold_a: assert property (!tx_valid[0] |=> !tx_out_valid[0] && $stable(tx_data_out[7:0]))
      else $error("tx output moved while idle");
   rx_latency_a: assert property (rx_valid[0] |=> rx_out_valid[0])
      else $error("rx output valid missing");
   rx_hold_a: assert property (!rx_valid[0] |=> $stable(rx_data_out[7:0]))
      else $error("rx output moved while idle");
endmodule
bind eprc_top eprc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_valid(tx_valid), .tx_out_valid(tx_out_valid), .tx_data_out(tx_data_out),
   .rx_valid(rx_valid), .rx_out_valid(rx_out_valid), .rx_data_out(rx_data_out));
`default_nettype wire

// ### sim/eprc_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
module eprc_frame_src (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        go,
   input wire logic [1:0]  nfr,
   input wire logic        mf_on,
   output logic            valid,
   output logic [4:0]      slot,
   output logic [7:0]      data,
   output logic [3:0]      sig,
   output logic            fstart,
   output logic            mf_first,
   output logic            mf_act,
   output logic            busy
);
   logic       run_q;
   logic [1:0] frm_q;
   logic [4:0] cnt_q;
   // Idle data and sig lines show inverted values so stale data cannot pass for fresh
   assign valid = run_q;
   assign slot = run_q ? cnt_q : 5'h0;
   assign data = run_q ? {3'h2, slot} : ~{3'h2, slot};
   assign sig = run_q ? (slot[3:0] ^ {2'h0, frm_q}) : ~slot[3:0];
   assign fstart = run_q && slot == 5'h0;
   assign mf_first = run_q && frm_q == 2'h0;
   assign mf_act = mf_on;
   assign busy = run_q | go;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         frm_q <= 2'h0;
      end else if (go) begin
         run_q <= 1'b1;
         frm_q <= 2'h0;
      end else if (run_q && slot == 5'h1f) begin
         frm_q <= frm_q + 2'h1;
         run_q <= (frm_q + 2'h1 != nfr);
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 5'h0;
      else cnt_q <= (go || !run_q) ? 5'h0 : cnt_q + 5'h1;
   end
endmodule
`default_nettype wire

// ### sim/e1_payload_replace_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "eprc_consts.vh"
module e1_payload_replace_ctrl_test;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic        go = 0, mf_on = 0, valid, fst, mff, mfa, sbusy, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, tdo, rdo;
   logic [1:0]  nfr = 1;
   logic [4:0]  slot, ps = 0;
   logic [7:0]  data, rd, txd[32], txs[32], rxd[32], rxs[32];
   logic [3:0]  sig, tov, rov;
   logic [15:0] tso, rso;
   int          err_total = 0, total_checks = 0;
   localparam logic [7:0] RX = 8'h5;
   always #25 pclk = ~pclk;
   eprc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_valid({4{valid}}), .tx_slot({4{slot}}), .tx_data_in({4{data}}),
      .tx_signaling_in({4{sig}}), .tx_frame_start({4{fst}}), .tx_mf_first({4{mff}}),
      .tx_mf_active({4{mfa}}), .tx_loop_data({4{~data}}), .tx_out_valid(tov),
      .tx_data_out(tdo), .tx_sig_out(tso), .rx_valid({4{valid}}), .rx_slot({4{slot}}),
      .rx_data_in({4{data}}), .rx_sig_in({4{sig}}), .rx_frame_start({4{fst}}),
      .rx_mf_first({4{mff}}), .rx_mf_active({4{mfa}}), .rx_out_valid(rov),
      .rx_data_out(rdo), .rx_signaling_out(rso));
   eprc_frame_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .nfr(nfr), .mf_on(mf_on),
      .valid(valid), .slot(slot), .data(data), .sig(sig), .fstart(fst), .mf_first(mff),
      .mf_act(mfa), .busy(sbusy));
   always @(posedge pclk) begin
      if (tov[0]) begin
         txd[ps] = tdo[7:0];
         txs[ps] = {4'h0, tso[3:0]};
      end
      if (rov[0]) begin
         rxd[ps] = rdo[7:0];
         rxs[ps] = {4'h0, rso[3:0]};
      end
      ps = slot;
   end
   function logic [11:0] ad(input logic [1:0] l, input logic [7:0] i);
      return {l, i, 2'h0};
   endfunction
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1) err_total++;
      rd = prdata[7:0];
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task idle(input logic [7:0] o, input logic [1:0] l);
      int n;
      n = 0;
      do apb(0, ad(l, `EPRC_IDX_TX_STATUS + o), 0); while (rd[0] !== 1'b0 && ++n < 10);
      if (rd[0] !== 1'b0) err_total++;
   endtask
   task iwr(input logic [7:0] o, input logic [1:0] l, input logic [6:0] a, input logic [7:0] d);
      apb(1, ad(l, `EPRC_IDX_TX_DATA + o), d);
      apb(1, ad(l, `EPRC_IDX_TX_CTRL + o), {1'b0, a});
      idle(o, l);
   endtask
   task ird(input logic [7:0] o, input logic [1:0] l, input logic [6:0] a);
      apb(1, ad(l, `EPRC_IDX_TX_CTRL + o), {1'b1, a});
      idle(o, l);
      apb(0, ad(l, `EPRC_IDX_TX_DATA + o), 0);
   endtask
   task run(input logic [1:0] n);
      int k;
      @(posedge pclk);
      nfr <= n;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      k = 0;
      while (sbusy !== 1'b0 && k < 200) begin
         @(posedge pclk);
         k++;
      end
      if (sbusy !== 1'b0) err_total++;
      repeat (2) @(posedge pclk);
   endtask
   task t_regs;
      for (int k = 0; k < 10; k++) begin
         apb(0, ad(0, `EPRC_IDX_TX_STATUS + 8'(k)), 0);
         chk("reset", rd, k == 3 ? `EPRC_TX_CFG_RST : 8'h00);
         chk("err", {7'h0, er}, 8'h0);
      end
      apb(0, ad(0, 8'h10), 0);
      chk("unmapped", {7'h0, er}, 8'h1);
      apb(0, ad(3, `EPRC_IDX_TX_CFG) | 12'h1, 0);
      chk("misalign", {7'h0, er}, 8'h1);
      apb(1, ad(3, `EPRC_IDX_TX_CFG) | 12'h1, 8'h00);
      chk("misalign wr", {7'h0, er}, 8'h1);
      apb(0, ad(3, `EPRC_IDX_TX_CFG), 0);
      chk("misalign kept", rd, `EPRC_TX_CFG_RST);
   endtask
   task t_ind;
      iwr(0, 1, 7'h45, 8'h1a);
      iwr(RX, 2, 7'h5f, 8'h3c);
      apb(1, ad(1, `EPRC_IDX_TX_CTRL), 8'hc5);
      apb(0, ad(1, `EPRC_IDX_TX_STATUS), 0);
      chk("busy", rd, 8'h1);
      idle(0, 1);
      apb(0, ad(1, `EPRC_IDX_TX_DATA), 0);
      chk("ind tx", rd, 8'h1a);
      ird(RX, 2, 7'h5f);
      chk("ind rx", rd, 8'h3c);
      ird(0, 2, 7'h45);
      chk("link", rd, 8'h00);
      iwr(0, 0, 7'h40, 8'h77);
      ird(0, 0, 7'h40);
      chk("hole", rd, 8'h00);
   endtask
   task t_data;
      for (int s = 0; s < 32; s++) begin
         iwr(0, 0, 7'h20 + 7'(s), 8'h3c ^ 8'(s));
         iwr(RX, 0, 7'h20 + 7'(s), 8'hc3 ^ 8'(s));
      end
      for (int k = 0; k < 2; k++) begin
         apb(1, ad(0, `EPRC_IDX_TX_EN + RX * 8'(k)), 8'h1);
         apb(1, ad(0, `EPRC_IDX_TX_CFG + RX * 8'(k)), 8'h1);
      end
      run(1);
      for (int s = 0; s < 32; s++) begin
         chk("trunk", txd[s], 8'h3c ^ 8'(s));
         chk("rx trunk", rxd[s], 8'hc3 ^ 8'(s));
      end
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h4);
      run(1);
      for (int s = 0; s < 32; s++) chk("loop", txd[s], ~(8'h40 + 8'(s)));
      iwr(0, 0, 7'h03, 8'h20);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h0);
      run(1);
      chk("slot sel", txd[3], 8'h3f);
      chk("slot pass", txd[4], 8'h44);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h2);
      run(1);
      chk("alaw", {7'h0, txd[7] inside {8'h34, 8'h21, 8'hb4, 8'ha1}}, 8'h1);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h3);
      apb(1, ad(0, `EPRC_IDX_RX_CFG), 8'h2);
      run(1);
      chk("ulaw", {7'h0, txd[7] inside {8'h1e, 8'h0b, 8'h9e, 8'h8b}}, 8'h1);
      chk("rx alaw", {7'h0, rxd[7] inside {8'h34, 8'h21, 8'hb4, 8'ha1}}, 8'h1);
      apb(1, ad(0, `EPRC_IDX_TX_EN), 8'h0);
      apb(1, ad(0, `EPRC_IDX_RX_EN), 8'h0);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h1);
      run(1);
      chk("disabled", txd[9], 8'h49);
      chk("rx disabled", rxd[9], 8'h49);
   endtask
   task t_sig;
      apb(1, ad(0, `EPRC_IDX_TX_EN), 8'h1);
      apb(1, ad(0, `EPRC_IDX_RX_EN), 8'h1);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h40);
      iwr(0, 0, 7'h41, 8'h0c);
      iwr(0, 0, 7'h42, 8'h15);
      run(1);
      chk("gcond1", txs[1], 8'h0c);
      chk("gcond17", txs[17], 8'h00);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h0);
      run(1);
      chk("cond off", txs[1], 8'h01);
      chk("cond on", txs[2], 8'h05);
      apb(1, ad(0, `EPRC_IDX_TX_CFG), 8'h80);
      apb(1, ad(0, `EPRC_IDX_RX_CFG), 8'h80);
      mf_on <= 1;
      run(2);
      chk("tx snap", txs[6], 8'h06);
      chk("rx snap", rxs[6], 8'h06);
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      err_total++;
      final_report;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_ind;
      t_data;
      t_sig;
      final_report;
   end
endmodule
`default_nettype wire
